// ===== verilog/log_framer_pkg.sv
// constants and carriers for the measurement log block framer
// assumes one 25 MHz clock domain; no software-visible registers
package log_framer_pkg;

  // buffer and frame sizing
  localparam int LOG_DEPTH          = 8000;
  localparam int FRAME_MAX_ENTRIES  = 1000;
  localparam int OVERFLOW_DROP      = 1000;
  localparam int ENTRY_BYTES        = 12;
  localparam int LEN_BASE           = 18;
  localparam int LEN_DIGITS         = 8;

  // header byte positions within a frame
  localparam int POS_START          = 0;
  localparam int POS_NDIG           = 1;
  localparam int POS_LEN            = 2;
  localparam int POS_RSV            = 10;
  localparam int POS_CHK            = 12;
  localparam int POS_FCNT           = 16;
  localparam int POS_PER            = 20;
  localparam int POS_NUM            = 24;
  localparam int POS_HDR_LAST       = 27;

  // fixed codes
  localparam logic [7:0] START_CODE       = 8'h23;
  localparam logic [7:0] DIGIT_COUNT_CODE = 8'h38;
  localparam logic [7:0] ASCII_ZERO       = 8'h30;
  localparam logic [7:0] END_CODE         = 8'h0a;
  localparam logic [7:0] RESERVED_BYTE    = 8'h00;

  // fetch counter wrap point
  localparam logic [31:0] FETCH_CNT_MAX   = 32'h773593ff;

  // log state command values
  localparam logic [1:0] LOG_CMD_STOP     = 2'h0;
  localparam logic [1:0] LOG_CMD_STORAGE  = 2'h1;
  localparam logic [1:0] LOG_CMD_HOST     = 2'h2;

  // status word regulation bits
  localparam int STATUS_CV_BIT      = 8;
  localparam int STATUS_CP_BIT      = 9;
  localparam int STATUS_CC_BIT      = 10;

  // reset values
  localparam logic [12:0] PTR_RESET       = 13'h0000;
  localparam logic [31:0] FETCH_CNT_RESET = 32'h00000000;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] voltage_mv;
    logic [31:0] current_ma;
  } log_entry_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } stream_beat_t;

  typedef enum logic [1:0] {
    MODE_OFF     = 2'b00,
    MODE_STORAGE = 2'b01,
    MODE_HOST    = 2'b10
  } log_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SUM   = 3'b001,
    ST_HDR   = 3'b011,
    ST_CELLS = 3'b010,
    ST_TAIL  = 3'b110
  } framer_state_t;

endpackage

// ===== verilog/measurement_log_block_framer.sv
// measurement log buffer and binary block frame generator
// assumes commands, fetches and samples are synchronous to ref_clk_i
// Behaviour
// - buffer holds up to 8000 entries while logging
// - each frame carries at most 1000 entries
// - value 2 starts host logging, 1 selects storage
// - value 0 stops logging
// - sent entries are freed; fetches may repeat
// - no entries returned while logging is stopped
// - outside a frame, overflow past 8000 drops oldest 1000 entries
// - stop clears all buffered entries
// - fields sent contiguously in fixed frame order
// - first byte is hash, 0x23
// - second byte is ASCII eight, 0x38
// - eight ASCII decimal digits of byte length
// - two reserved bytes sent as zero
// - checksum sums bytes after it, LSB first
// - fetch counter LSB first, wraps, restarts at zero
// - sample period in ms, LSB first
// - entry count field, LSB first
// - entries oldest first: status, voltage, current
// - status word 32 bits, LSB first
// - voltage in millivolts, LSB first
// - current in milliamperes, LSB first
// - last byte is line feed, 0x0a
// - empty fetch gives zeroed frame without entries
// - constant-power also sets constant-voltage bit
`timescale 1ns/1ps
module measurement_log_block_framer (
  // clock and reset
  input  wire logic                          ref_clk_i,
  input  wire logic                          resetn_i,
  // host commands
  input  wire logic                          log_state_command_valid_i,
  input  wire logic [1:0]                    log_state_command_value_i,
  input  wire logic                          log_fetch_request_i,
  input  wire logic [31:0]                   sample_period_ms_i,
  // measurement samples
  input  wire logic                          sample_valid_i,
  input  wire log_framer_pkg::log_entry_t    sample_i,
  // response byte stream
  output logic                               stream_valid_o,
  output log_framer_pkg::stream_beat_t       stream_beat_o,
  input  wire logic                          stream_ready_i,
  // status
  output log_framer_pkg::log_mode_t          log_mode_o,
  output logic [12:0]                        entry_count_o,
  output logic                               fetch_refused_o
);
  import log_framer_pkg::*;

  log_entry_t    log_mem [LOG_DEPTH];
  framer_state_t state;
  log_mode_t     mode;
  logic [12:0]   wr_ptr;
  logic [12:0]   rd_ptr;
  logic [12:0]   count;
  logic [31:0]   fetch_cnt;
  logic [31:0]   frame_cnt;
  logic [31:0]   frame_period;
  logic [9:0]    frame_n;
  logic [15:0]   frame_len;
  logic [31:0]   checksum;
  logic [12:0]   scan_ptr;
  logic [9:0]    scan_left;
  logic [4:0]    hdr_pos;
  logic [3:0]    cell_byte;
  logic          cleared_in_frame;
  stream_beat_t  slot0;
  stream_beat_t  slot1;
  logic          valid0;
  logic          valid1;
  stream_beat_t  gen_beat;
  logic          gen_valid;
  logic          push;
  logic          pop;
  logic          cmd_start;
  logic          cmd_stop;
  logic          cmd_clear;
  logic          take_sample;
  logic          overflow;
  logic          fetch_accept;
  logic          frame_done;
  logic [9:0]    next_frame_n;
  log_entry_t    sample_fixed;
  log_entry_t    scan_entry;

  function automatic logic [12:0] ptr_add(input logic [12:0] p, input logic [12:0] d);
    logic [13:0] s;
    s = {1'b0, p} + {1'b0, d};
    if (s >= 14'(LOG_DEPTH)) begin
      s = s - 14'(LOG_DEPTH);
    end
    return s[12:0];
  endfunction

  function automatic logic [31:0] byte_sum(input logic [31:0] w);
    return 32'(w[7:0]) + 32'(w[15:8]) + 32'(w[23:16]) + 32'(w[31:24]);
  endfunction

  function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] idx);
    return w[{idx, 3'b000} +: 8];
  endfunction

  function automatic logic [7:0] len_digit(input logic [15:0] len, input logic [2:0] k);
    logic [15:0] tmp;
    tmp = len;
    for (int i = 0; i < LEN_DIGITS - 1; i++) begin
      if (i < (LEN_DIGITS - 1) - int'(k)) begin
        tmp = tmp / 16'h000a;
      end
    end
    tmp = tmp % 16'h000a;
    return ASCII_ZERO + tmp[7:0];
  endfunction

  // command decode
  assign cmd_start = log_state_command_valid_i && (log_state_command_value_i == LOG_CMD_HOST);
  assign cmd_stop  = log_state_command_valid_i && (log_state_command_value_i == LOG_CMD_STOP);
  assign cmd_clear = log_state_command_valid_i;

  // a full buffer during a frame drops the new sample, since the in-flight entries must stay put
  assign take_sample  = sample_valid_i && (mode == MODE_HOST) && !cmd_clear &&
                        !((count == 13'(LOG_DEPTH)) && (state != ST_IDLE));
  assign overflow     = take_sample && (count == 13'(LOG_DEPTH));
  assign fetch_accept = log_fetch_request_i && (mode == MODE_HOST) && (state == ST_IDLE) &&
                        !cmd_clear;
  assign next_frame_n = (count > 13'(FRAME_MAX_ENTRIES)) ? 10'(FRAME_MAX_ENTRIES) : count[9:0];
  assign frame_done   = (state == ST_TAIL) && push;

  // constant-power operation reports constant-voltage as well
  always_comb begin
    sample_fixed = sample_i;
    if (sample_i.status[STATUS_CP_BIT]) begin
      sample_fixed.status[STATUS_CV_BIT] = 1'b1;
    end
  end

  // log mode
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode <= MODE_OFF;
    end else if (cmd_start) begin
      mode <= MODE_HOST;
    end else if (cmd_stop) begin
      mode <= MODE_OFF;
    end else if (log_state_command_valid_i && (log_state_command_value_i == LOG_CMD_STORAGE)) begin
      mode <= MODE_STORAGE;
    end
  end

  // entry storage
  always_ff @(posedge ref_clk_i) begin
    if (take_sample) begin
      log_mem[wr_ptr] <= sample_fixed;
    end
  end

  // queue pointers and occupancy
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr <= PTR_RESET;
      rd_ptr <= PTR_RESET;
      count  <= 13'h0000;
    end else if (cmd_clear) begin
      rd_ptr <= wr_ptr;
      count  <= 13'h0000;
    end else begin
      if (take_sample) begin
        wr_ptr <= ptr_add(wr_ptr, 13'h0001);
      end
      if (overflow) begin
        rd_ptr <= ptr_add(rd_ptr, 13'(OVERFLOW_DROP));
        count  <= count - 13'(OVERFLOW_DROP) + 13'h0001;
      end else if (frame_done && !cleared_in_frame) begin
        rd_ptr <= ptr_add(rd_ptr, 13'(frame_n));
        count  <= count - 13'(frame_n) + 13'(take_sample);
      end else if (take_sample) begin
        count  <= count + 13'h0001;
      end
    end
  end

  // fetch counter
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fetch_cnt <= FETCH_CNT_RESET;
    end else if (cmd_start) begin
      fetch_cnt <= FETCH_CNT_RESET;
    end else if (fetch_accept) begin
      fetch_cnt <= (fetch_cnt == FETCH_CNT_MAX) ? FETCH_CNT_RESET : fetch_cnt + 32'h00000001;
    end
  end

  assign scan_entry = log_mem[scan_ptr];

  // frame sequencing
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state            <= ST_IDLE;
      frame_cnt        <= 32'h00000000;
      frame_period     <= 32'h00000000;
      frame_n          <= 10'h000;
      frame_len        <= 16'h0000;
      checksum         <= 32'h00000000;
      scan_ptr         <= PTR_RESET;
      scan_left        <= 10'h000;
      hdr_pos          <= 5'h00;
      cell_byte        <= 4'h0;
      cleared_in_frame <= 1'b0;
    end else begin
      if (cmd_clear && (state != ST_IDLE)) begin
        cleared_in_frame <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (fetch_accept) begin
            frame_cnt        <= fetch_cnt;
            frame_period     <= sample_period_ms_i;
            frame_n          <= next_frame_n;
            frame_len        <= 16'(LEN_BASE) + 16'(next_frame_n) * 16'(ENTRY_BYTES);
            checksum         <= byte_sum(fetch_cnt) + byte_sum(sample_period_ms_i) +
                                byte_sum(32'(next_frame_n));
            scan_ptr         <= rd_ptr;
            scan_left        <= next_frame_n;
            hdr_pos          <= 5'h00;
            cleared_in_frame <= 1'b0;
            state            <= ST_SUM;
          end
        end
        ST_SUM: begin
          if (scan_left == 10'h000) begin
            scan_ptr  <= ptr_add(scan_ptr, 13'(LOG_DEPTH) - 13'(frame_n));  // rewind; rd_ptr moves on a mid-frame command
            scan_left <= frame_n;
            cell_byte <= 4'h0;
            state     <= ST_HDR;
          end else begin
            checksum  <= checksum + byte_sum(scan_entry.status) + byte_sum(scan_entry.voltage_mv) +
                         byte_sum(scan_entry.current_ma);
            scan_ptr  <= ptr_add(scan_ptr, 13'h0001);
            scan_left <= scan_left - 10'h001;
          end
        end
        ST_HDR: begin
          if (push) begin
            hdr_pos <= hdr_pos + 5'h01;
            if (hdr_pos == 5'(POS_HDR_LAST)) begin
              state <= (frame_n == 10'h000) ? ST_TAIL : ST_CELLS;
            end
          end
        end
        ST_CELLS: begin
          if (push) begin
            if (cell_byte == 4'(ENTRY_BYTES - 1)) begin
              cell_byte <= 4'h0;
              scan_ptr  <= ptr_add(scan_ptr, 13'h0001);
              scan_left <= scan_left - 10'h001;
              if (scan_left == 10'h001) begin
                state <= ST_TAIL;
              end
            end else begin
              cell_byte <= cell_byte + 4'h1;
            end
          end
        end
        ST_TAIL: begin
          if (push) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // byte generator
  always_comb begin
    gen_beat  = '{data: 8'h00, last: 1'b0};
    gen_valid = 1'b0;
    case (state)
      ST_HDR: begin
        gen_valid = 1'b1;
        if (hdr_pos == 5'(POS_START)) begin
          gen_beat.data = START_CODE;
        end else if (hdr_pos == 5'(POS_NDIG)) begin
          gen_beat.data = DIGIT_COUNT_CODE;
        end else if (hdr_pos < 5'(POS_RSV)) begin
          gen_beat.data = len_digit(frame_len, 3'(hdr_pos - 5'(POS_LEN)));
        end else if ((hdr_pos < 5'(POS_CHK)) || (frame_n == 10'h000)) begin
          gen_beat.data = RESERVED_BYTE;
        end else if (hdr_pos < 5'(POS_FCNT)) begin
          gen_beat.data = word_byte(checksum, hdr_pos[1:0]);
        end else if (hdr_pos < 5'(POS_PER)) begin
          gen_beat.data = word_byte(frame_cnt, hdr_pos[1:0]);
        end else if (hdr_pos < 5'(POS_NUM)) begin
          gen_beat.data = word_byte(frame_period, hdr_pos[1:0]);
        end else begin
          gen_beat.data = word_byte(32'(frame_n), hdr_pos[1:0]);
        end
      end
      ST_CELLS: begin
        gen_valid = 1'b1;
        case (cell_byte[3:2])
          2'h0:    gen_beat.data = word_byte(scan_entry.status, cell_byte[1:0]);
          2'h1:    gen_beat.data = word_byte(scan_entry.voltage_mv, cell_byte[1:0]);
          2'h2:    gen_beat.data = word_byte(scan_entry.current_ma, cell_byte[1:0]);
          default: gen_beat.data = 8'h00;
        endcase
      end
      ST_TAIL: begin
        gen_valid = 1'b1;
        gen_beat  = '{data: END_CODE, last: 1'b1};
      end
      default: begin
        gen_valid = 1'b0;
      end
    endcase
  end

  // two-entry output buffer; the generator stalls while the second slot is taken
  assign push = gen_valid && !valid1;
  assign pop  = valid0 && stream_ready_i;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slot0  <= '{data: 8'h00, last: 1'b0};
      slot1  <= '{data: 8'h00, last: 1'b0};
      valid0 <= 1'b0;
      valid1 <= 1'b0;
    end else if (pop) begin
      if (valid1) begin
        slot0  <= slot1;
        slot1  <= gen_beat;
        valid1 <= push;
      end else begin
        slot0  <= gen_beat;
        valid0 <= push;
      end
    end else if (push) begin
      if (!valid0) begin
        slot0  <= gen_beat;
        valid0 <= 1'b1;
      end else begin
        slot1  <= gen_beat;
        valid1 <= 1'b1;
      end
    end
  end

  // refused fetch flag, one cycle per ignored request
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fetch_refused_o <= 1'b0;
    end else begin
      fetch_refused_o <= log_fetch_request_i && !fetch_accept;
    end
  end

  assign stream_valid_o = valid0;
  assign stream_beat_o  = slot0;
  assign log_mode_o     = mode;
  assign entry_count_o  = count;

endmodule

// ===== tb/host_sink_model.sv
// host side of the response stream: a byte sink that may stall
// assumes the framer clock; stalls come from a free-running lfsr
`timescale 1ns/1ps
module host_sink_model (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  // stall control
  input  wire logic slow_i,
  // stream handshake
  output logic      stream_ready_o
);
  logic [7:0] lfsr;

  // ready is registered so it never follows valid in the same cycle
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lfsr           <= 8'h5b;
      stream_ready_o <= 1'b0;
    end else begin
      lfsr           <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      stream_ready_o <= !slow_i || lfsr[0];
    end
  end
endmodule

// ===== tb/log_framer_checker_checker.sv
// port assertions for the measurement log block framer
// assumes a single clock domain; bound to every framer instance
`timescale 1ns/1ps
module log_framer_checker
  import log_framer_pkg::*;
(
  // clock and reset
  input wire logic                         ref_clk_i,
  input wire logic                         resetn_i,
  // host commands
  input wire logic                         log_state_command_valid_i,
  input wire logic [1:0]                   log_state_command_value_i,
  input wire logic                         log_fetch_request_i,
  input wire logic                         sample_valid_i,
  // stream and status
  input wire logic                         stream_valid_o,
  input wire log_framer_pkg::stream_beat_t stream_beat_o,
  input wire logic                         stream_ready_i,
  input wire log_framer_pkg::log_mode_t    log_mode_o,
  input wire logic [12:0]                  entry_count_o,
  input wire logic                         fetch_refused_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  logic [15:0] idx;
  logic        busy;
  wire         hs  = stream_valid_o && stream_ready_i;
  wire         cmd = log_state_command_valid_i;

  // byte position within the current frame
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) idx <= 16'h0000;
    else if (hs) idx <= stream_beat_o.last ? 16'h0000 : idx + 16'h0001;
  end

  // conservative: a frame counts as pending until its end byte is taken
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) busy <= 1'b0;
    else if (log_fetch_request_i && log_mode_o == MODE_HOST && !cmd) busy <= 1'b1;
    else if (hs && stream_beat_o.last) busy <= 1'b0;
  end

  start_code_a: assert property (stream_valid_o && idx == 16'h0000 |-> stream_beat_o.data == START_CODE)
    else $error("frame does not open with the start code");
  digit_code_a: assert property (stream_valid_o && idx == 16'h0001 |-> stream_beat_o.data == DIGIT_COUNT_CODE)
    else $error("digit count byte wrong");
  length_digits_a: assert property (stream_valid_o && idx >= 16'h0002 && idx <= 16'h0009
    |-> stream_beat_o.data inside {[8'h30:8'h39]})
    else $error("length field byte is not a decimal digit");
  reserved_zero_a: assert property (stream_valid_o && (idx == 16'h000a || idx == 16'h000b)
    |-> stream_beat_o.data == 8'h00)
    else $error("reserved byte not zero");
  end_code_a: assert property (stream_valid_o && stream_beat_o.last |-> stream_beat_o.data == END_CODE)
    else $error("last byte is not the end code");
  beat_hold_a: assert property (stream_valid_o && !stream_ready_i |=> stream_valid_o && $stable(stream_beat_o))
    else $error("stream byte changed while stalled");
  host_start_a: assert property (cmd && log_state_command_value_i == LOG_CMD_HOST
    |=> log_mode_o == MODE_HOST && entry_count_o == 13'h0000)
    else $error("host logging did not start empty");
  stop_clear_a: assert property (cmd && log_state_command_value_i == LOG_CMD_STOP
    |=> log_mode_o == MODE_OFF && entry_count_o == 13'h0000)
    else $error("stop did not halt and clear");
  off_refuse_a: assert property (log_fetch_request_i && log_mode_o != MODE_HOST && !cmd |=> fetch_refused_o)
    else $error("fetch while stopped was not refused");
  off_silent_a: assert property (log_mode_o != MODE_HOST && !busy |-> !stream_valid_o)
    else $error("stream active while logging stopped");
  depth_cap_a: assert property (entry_count_o <= 13'h1f40)
    else $error("entry count above buffer depth");
  overflow_drop_a: assert property (sample_valid_i && log_mode_o == MODE_HOST && !cmd && !busy
    && entry_count_o == 13'h1f40 |=> entry_count_o == 13'h1b59)
    else $error("overflow did not drop the oldest block");

  cover property (hs && stream_beat_o.last);
  cover property (stream_valid_o && !stream_ready_i);
  cover property (fetch_refused_o);
  cover property (entry_count_o == 13'h1f40 && sample_valid_i);
endmodule

bind measurement_log_block_framer log_framer_checker u_log_framer_checker (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .log_state_command_valid_i(log_state_command_valid_i),
  .log_state_command_value_i(log_state_command_value_i), .log_fetch_request_i(log_fetch_request_i),
  .sample_valid_i(sample_valid_i), .stream_valid_o(stream_valid_o), .stream_beat_o(stream_beat_o),
  .stream_ready_i(stream_ready_i), .log_mode_o(log_mode_o), .entry_count_o(entry_count_o),
  .fetch_refused_o(fetch_refused_o));

// ===== tb/test_measurement_log_block_framer.sv
// self-checking bench for the measurement log block framer
// assumes the host sink model and the bound port checker
`timescale 1ns/1ps
module test_measurement_log_block_framer;
  import log_framer_pkg::*;
  logic         ref_clk_i, resetn_i, cmd_v, fetch, samp_v, ready, slow, refused, sv, host_on;
  logic [1:0]   cmd_val;
  logic [31:0]  period, fcnt;
  logic [12:0]  cnt;
  log_entry_t   samp;
  stream_beat_t beat;
  log_mode_t    mode;
  log_entry_t   model_q[$];
  logic [8:0]   exp_q[$];
  int           fail_count, checks_done, cycles;

  measurement_log_block_framer u_measurement_log_block_framer (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .log_state_command_valid_i(cmd_v),
    .log_state_command_value_i(cmd_val), .log_fetch_request_i(fetch), .sample_period_ms_i(period),
    .sample_valid_i(samp_v), .sample_i(samp), .stream_valid_o(sv), .stream_beat_o(beat),
    .stream_ready_i(ready), .log_mode_o(mode), .entry_count_o(cnt), .fetch_refused_o(refused));
  host_sink_model u_host_sink_model (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .slow_i(slow),
    .stream_ready_o(ready));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic command(input logic [1:0] v);
    cmd_val = v;
    cmd_v = 1'b1;
    @(negedge ref_clk_i);
    cmd_v = 1'b0;
    model_q.delete();
    // value 3 only clears the buffer; mode and fetch counter carry on
    if (v != 2'h3) host_on = (v == LOG_CMD_HOST);
    if (v == LOG_CMD_HOST) fcnt = 32'h0;
    @(negedge ref_clk_i);
    check("log mode", 32'(mode), 32'(v == 2'h3 ? (host_on ? LOG_CMD_HOST : LOG_CMD_STOP) : v));
    check("entry count", 32'(cnt), 32'h0);
  endtask

  task automatic push_samples(input int n);
    log_entry_t e;
    for (int i = 0; i < n; i++) begin
      e = {$urandom, $urandom, $urandom};
      samp = e;
      samp_v = 1'b1;
      if (e.status[STATUS_CP_BIT]) e.status[STATUS_CV_BIT] = 1'b1;
      if (host_on && model_q.size() == LOG_DEPTH) model_q = model_q[OVERFLOW_DROP:$];
      if (host_on) model_q.push_back(e);
      @(negedge ref_clk_i);
    end
    samp_v = 1'b0;
    check("entry count", 32'(cnt), 32'(model_q.size()));
  endtask

  // expected bytes are queued before the request, so the monitor never starves
  task automatic do_fetch(input bit take);
    logic [31:0] w[$];
    log_entry_t  e;
    logic [31:0] sum;
    int          n, len, p;
    n = (model_q.size() > FRAME_MAX_ENTRIES) ? FRAME_MAX_ENTRIES : model_q.size();
    period = $urandom;
    if (take) begin
      w.push_back(n == 0 ? 32'h0 : fcnt);
      w.push_back(n == 0 ? 32'h0 : period);
      w.push_back(32'(n));
      for (int i = 0; i < n; i++) begin
        e = model_q.pop_front();
        w.push_back(e.status);
        w.push_back(e.voltage_mv);
        w.push_back(e.current_ma);
      end
      sum = 32'h0;
      foreach (w[i])
        for (int b = 0; b < 4; b++) sum += 32'(w[i][8*b+:8]);
      len = LEN_BASE + ENTRY_BYTES * n;
      exp_q.push_back({START_CODE, 1'b0});
      exp_q.push_back({DIGIT_COUNT_CODE, 1'b0});
      p = 10000000;
      for (int d = 0; d < LEN_DIGITS; d++) begin
        exp_q.push_back({ASCII_ZERO + 8'((len / p) % 10), 1'b0});
        p = p / 10;
      end
      repeat (2) exp_q.push_back({RESERVED_BYTE, 1'b0});
      w.push_front(sum);
      foreach (w[i])
        for (int b = 0; b < 4; b++) exp_q.push_back({w[i][8*b+:8], 1'b0});
      exp_q.push_back({END_CODE, 1'b1});
      fcnt++;
    end
    fetch = 1'b1;
    @(negedge ref_clk_i);
    fetch = 1'b0;
    check("fetch refused", 32'(refused), 32'(!take));
  endtask

  task automatic wait_frame();
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 30000) begin
      @(negedge ref_clk_i);
      k++;
    end
    check("frame drained", 32'(exp_q.size()), 32'h0);
    check("entry count", 32'(cnt), 32'(model_q.size()));
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // monitor: each taken byte is matched against the oldest queued note
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      test_done();
    end else if (resetn_i && sv && ready)
      check("stream byte", 32'(beat), 32'(exp_q.size() != 0 ? exp_q.pop_front() : 9'h1ff));
  end

  initial begin
    resetn_i = 1'b0;
    cmd_v = 1'b0;
    cmd_val = 2'h0;
    fetch = 1'b0;
    samp_v = 1'b0;
    samp = '0;
    period = 32'h0;
    slow = 1'b1;
    host_on = 1'b0;
    fcnt = 32'h0;
    void'($urandom(39889));
    repeat (16) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    @(negedge ref_clk_i);
    check("entry count", 32'(cnt), 32'h0);
    do_fetch(1'b0);
    command(LOG_CMD_STORAGE);
    push_samples(2);
    do_fetch(1'b0);
    command(LOG_CMD_HOST);
    do_fetch(1'b1);
    wait_frame();
    push_samples(3);
    do_fetch(1'b1);
    @(negedge ref_clk_i);
    do_fetch(1'b0);
    wait_frame();
    push_samples(5);
    command(2'h3);
    push_samples(1);
    do_fetch(1'b1);
    wait_frame();
    command(LOG_CMD_STOP);
    do_fetch(1'b0);
    command(LOG_CMD_HOST);
    push_samples(2);
    do_fetch(1'b1);
    wait_frame();
    slow = 1'b0;
    push_samples(8001);
    do_fetch(1'b1);
    wait_frame();
    test_done();
  end
endmodule
